// ### edge_sync.sv
// edge_sync: two-flop synchroniser with rising and falling edge pulses
// assumes the input is asynchronous to clk_i
`timescale 1ns/100ps
module edge_sync
  import led_pwm_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // async level in
  input  wire logic async_i,
  // synchronised level and edges
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);
  logic meta;
  logic sync;
  logic prev;
  logic next_meta;
  logic next_sync;
  logic next_prev;

  always_comb begin
    next_meta = async_i;
    next_sync = meta;
    next_prev = sync;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  assign level_o = sync;
  assign rise_o  = sync & ~prev;
  assign fall_o  = ~sync & prev;
endmodule

// ### led_ctl_model.sv
// led_ctl_model: display controller driving the driver's pins
// assumes clk_i is the 4 ns clock; link clock pulses are 40 ns high with at least 44 ns low between them
`timescale 1ns/100ps
module led_ctl_model
  import led_pwm_pkg::*;
(
  // system clock
  input  wire logic clk_i,
  // pins toward the driver
  output ctl_pins_s pins_o,
  output logic      shift_clock_o,
  output logic      gray_clock_o
);
  initial begin
    pins_o = '{enable_n: 1'b1, blank: 1'b1, mode16: 1'b1, default: '0};
    shift_clock_o = 1'b0;
    gray_clock_o = 1'b0;
  end
  // data leads the rising edge by 10 clk cycles and holds 15 cycles past it
  task automatic shift_byte(input logic [7:0] b, input logic sel, input logic en_n);
    @(posedge clk_i);
    pins_o.data <= b;
    pins_o.select <= sel;
    pins_o.enable_n <= en_n;
    repeat (10) @(posedge clk_i);
    shift_clock_o <= 1'b1;
    repeat (10) @(posedge clk_i);
    shift_clock_o <= 1'b0;
    repeat (5) @(posedge clk_i);
    pins_o.data <= ~b; // stale byte must not pass for a valid one
  endtask
  // clock stands low between pulses
  task automatic gray_pulse();
    @(posedge clk_i);
    gray_clock_o <= 1'b1;
    repeat (10) @(posedge clk_i);
    gray_clock_o <= 1'b0;
    repeat (10) @(posedge clk_i);
  endtask
endmodule

// ### led_grayscale_pwm_driver.sv
// led_grayscale_pwm_driver: shift registers, latches, pwm and protection of the led sink driver
// assumes controller pins are asynchronous and much slower than clk_i; registers over classic wishbone
`timescale 1ns/100ps
module led_grayscale_pwm_driver
  import led_pwm_pkg::*;
(
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [3:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  output logic                      irq_o,
  // controller pins
  input  wire logic                 shift_clock_i,
  input  wire logic                 gray_count_clock_i,
  input  wire logic                 transfer_enable_i,
  input  wire logic                 register_select_i,
  input  wire logic                 latch_i,
  input  wire logic                 bright_default_ctrl_i,
  input  wire logic                 blank_i,
  input  wire logic                 mode_i,
  input  wire logic                 scan_watch_input_i,
  input  wire logic                 thermal_guard_enable_i,
  input  wire logic                 over_temp_i,
  input  wire logic [7:0]           parallel_data_in_i,
  // outputs
  output logic      [7:0]           cascade_data_out_o,
  output logic      [NUM_OUT-1:0]   led_sink_outputs_o,
  output logic      [BC_W-1:0]      brightness_o,
  output logic                      fault_o,
  output logic                      fault_oe_n_o
);
  // synchronised pins; the data byte is sampled only a full sync delay after it settled
  ctl_pins_s  pin_meta;
  ctl_pins_s  pin;
  logic       sclk_rise;
  logic       gclk_rise;
  logic       gclk_fall;
  logic       scan_rise;
  logic       scan_fall;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta <= '0;
      pin      <= '0;
    end else begin
      pin_meta <= '{enable_n: transfer_enable_i, select: register_select_i, latch: latch_i,
                    bright_default: bright_default_ctrl_i, blank: blank_i, mode16: mode_i,
                    scan: 1'b0, thermal_en: thermal_guard_enable_i, over_temp: over_temp_i,
                    data: parallel_data_in_i};
      pin      <= pin_meta;
    end
  end

  edge_sync u_sclk (.clk_i(clk_i), .rst_i(rst_i), .async_i(shift_clock_i),
                    .level_o(), .rise_o(sclk_rise), .fall_o());
  edge_sync u_gclk (.clk_i(clk_i), .rst_i(rst_i), .async_i(gray_count_clock_i),
                    .level_o(), .rise_o(gclk_rise), .fall_o(gclk_fall));
  edge_sync u_scan (.clk_i(clk_i), .rst_i(rst_i), .async_i(scan_watch_input_i),
                    .level_o(), .rise_o(scan_rise), .fall_o(scan_fall));

  // shift registers
  logic [7:0]      gs_shift [NUM_OUT];
  logic [7:0]      next_gs_shift [NUM_OUT];
  logic [BC_W-1:0] bc_shift;
  logic [BC_W-1:0] next_bc_shift;
  logic [7:0]      next_cascade;
  logic            shift_gs;
  logic            shift_bc;

  assign shift_gs = sclk_rise & ~pin.enable_n & ~pin.select;
  assign shift_bc = sclk_rise & ~pin.enable_n & pin.select;

  always_comb begin
    next_bc_shift = bc_shift;
    next_cascade  = cascade_data_out_o;
    for (int i = 0; i < NUM_OUT; i++) begin
      next_gs_shift[i] = gs_shift[i];
    end
    if (shift_bc) begin
      next_bc_shift = pin.data[BC_W-1:0];
    end
    if (shift_gs) begin
      // last stage depends on mode: byte 16 or byte 8 back
      next_cascade = pin.mode16 ? gs_shift[NUM_OUT-1] : gs_shift[NUM_OUT8-1];
      next_gs_shift[0] = pin.data;
      for (int i = 1; i < NUM_OUT; i++) begin
        next_gs_shift[i] = gs_shift[i-1];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bc_shift           <= '0;
      cascade_data_out_o <= '0;
      for (int i = 0; i < NUM_OUT; i++) begin
        gs_shift[i] <= '0;
      end
    end else begin
      bc_shift           <= next_bc_shift;
      cascade_data_out_o <= next_cascade;
      for (int i = 0; i < NUM_OUT; i++) begin
        gs_shift[i] <= next_gs_shift[i];
      end
    end
  end

  // latches modelled as enabled registers: transparent while latch high, gray-scale with select low, brightness with select and bright_default high
  logic [7:0]      gs_latch [NUM_OUT];
  logic [7:0]      next_gs_latch [NUM_OUT];
  logic [BC_W-1:0] next_brightness;
  logic            gs_open;
  logic            bc_open;
  logic            load_evt;
  logic [1:0]      trip_prev;
  logic [1:0]      next_trip_prev;

  assign gs_open  = pin.latch & ~pin.select;
  assign bc_open  = pin.latch & pin.select & pin.bright_default;
  assign load_evt = gs_open & ~trip_prev[1];

  always_comb begin
    next_brightness = brightness_o;
    if (!pin.bright_default) begin
      next_brightness = BC_DEFAULT;
    end else if (bc_open) begin
      next_brightness = bc_shift;
    end
    for (int i = 0; i < NUM_OUT; i++) begin
      next_gs_latch[i] = gs_open ? gs_shift[i] : gs_latch[i];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      brightness_o <= BC_DEFAULT;
      for (int i = 0; i < NUM_OUT; i++) begin
        gs_latch[i] <= '0;
      end
    end else begin
      brightness_o <= next_brightness;
      for (int i = 0; i < NUM_OUT; i++) begin
        gs_latch[i] <= next_gs_latch[i];
      end
    end
  end

  // wishbone registers
  logic [1:0]      ctrl;
  logic [WD_W-1:0] wd_limit;
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] mask;
  logic [1:0]      next_ctrl;
  logic [WD_W-1:0] next_wd_limit;
  logic [ST_W-1:0] next_status;
  logic [ST_W-1:0] next_mask;
  logic [31:0]     next_dat;
  logic            next_ack;
  logic            wr;
  logic [ST_W-1:0] events;
  logic            wd_trip;
  logic            therm_trip;

  assign wr     = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign events = {load_evt, therm_trip, wd_trip};

  always_comb begin
    next_ctrl     = ctrl;
    next_wd_limit = wd_limit;
    next_mask     = mask;
    next_status   = status;
    next_ack      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    next_dat      = '0;
    if (wr && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
      next_ctrl = wb_dat_i[1:0];
    end
    if (wr && wb_adr_i == REG_WDT) begin
      for (int b = 0; b < 3; b++) begin
        if (wb_sel_i[b]) begin
          next_wd_limit[b*8 +: 8] = wb_dat_i[b*8 +: 8];
        end
      end
    end
    if (wr && wb_adr_i == REG_MASK && wb_sel_i[0]) begin
      next_mask = wb_dat_i[ST_W-1:0];
    end
    if (wr && wb_adr_i == REG_STATUS && wb_sel_i[0]) begin
      next_status = status & ~wb_dat_i[ST_W-1:0];
    end
    // a new event wins over a same-cycle clear
    next_status = next_status | events;
    case (wb_adr_i)
      REG_CTRL:   next_dat = {30'h0, ctrl};
      REG_WDT:    next_dat = {8'h0, wd_limit};
      REG_STATUS: next_dat = {29'h0, status};
      REG_MASK:   next_dat = {29'h0, mask};
      default:    next_dat = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl     <= CTRL_RESET;
      wd_limit <= WD_RESET;
      status   <= '0;
      mask     <= '0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      ctrl     <= next_ctrl;
      wd_limit <= next_wd_limit;
      status   <= next_status;
      mask     <= next_mask;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  assign irq_o = |(status & mask);

  // protection: watchdog counts clk_i cycles since last scan edge
  logic [WD_W-1:0] wd_cnt;
  logic [WD_W-1:0] next_wd_cnt;
  logic            wd_fault;
  logic            next_wd_fault;
  logic            wd_active;
  logic            therm_fault;

  assign wd_active   = ctrl[CTRL_WD_EN] & ~ctrl[CTRL_WD_TIED];
  assign therm_fault = pin.thermal_en & pin.over_temp;
  assign therm_trip  = therm_fault & ~trip_prev[0];
  assign wd_trip     = next_wd_fault & ~wd_fault;

  always_comb begin
    // event edges come from settled levels; the first sync flop stays private
    next_trip_prev = {gs_open, therm_fault};
    next_wd_cnt   = wd_cnt;
    next_wd_fault = wd_fault;
    if (!wd_active || scan_rise || scan_fall) begin
      next_wd_cnt   = '0;
      next_wd_fault = 1'b0;
    end else if (wd_cnt >= wd_limit) begin
      next_wd_fault = 1'b1;
    end else begin
      next_wd_cnt = wd_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_cnt    <= '0;
      wd_fault  <= 1'b0;
      trip_prev <= '0;
    end else begin
      wd_cnt    <= next_wd_cnt;
      wd_fault  <= next_wd_fault;
      trip_prev <= next_trip_prev;
    end
  end

  // open-drain fault pin: enable low while pulling low
  assign fault_o      = 1'b0;
  assign fault_oe_n_o = ~(wd_fault | therm_fault);

  // pwm: 8-bit count of gray clock falls after arming
  pwm_state_e      state;
  pwm_state_e      next_state;
  logic [GS_W-1:0] gs_cnt;
  logic [GS_W-1:0] next_gs_cnt;
  logic [NUM_OUT-1:0] next_led;
  logic            kill;

  assign kill = pin.blank | wd_fault | therm_fault;

  always_comb begin
    next_state  = state;
    next_gs_cnt = gs_cnt;
    next_led    = led_sink_outputs_o;
    case (state)
      PWM_BLANK: begin
        next_gs_cnt = '0;
        if (!pin.blank) begin
          next_state = PWM_ARM;
        end
      end
      PWM_ARM: begin
        if (gclk_rise) begin
          next_state = PWM_RUN;
        end
      end
      PWM_RUN: begin
        if (gclk_fall) begin
          next_gs_cnt = gs_cnt + 1'b1;
        end
      end
      default: next_state = PWM_BLANK;
    endcase
    if (state == PWM_RUN && gclk_fall) begin
      for (int i = 0; i < NUM_OUT; i++) begin
        // lit while counted falls stay at or below the value upper outputs idle in 8-output mode
        next_led[i] = (next_gs_cnt <= gs_latch[i]) && (gs_latch[i] != '0) && (pin.mode16 || i < NUM_OUT8);
      end
    end
    if (pin.blank) begin
      next_state = PWM_BLANK;
    end
    if (kill) begin
      next_led = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state              <= PWM_BLANK;
      gs_cnt             <= '0;
      led_sink_outputs_o <= '0;
    end else begin
      state              <= next_state;
      gs_cnt             <= next_gs_cnt;
      led_sink_outputs_o <= next_led;
    end
  end
endmodule

// ### led_pwm_chk.sv
// led_pwm_chk: port-level assertions for the led driver
// assumes pin inputs reach the logic within six clk cycles
`timescale 1ns/100ps
module led_pwm_chk
  import led_pwm_pkg::*;
(
  // clock, reset, bus
  input wire logic         clk_i,
  input wire logic         rst_i,
  input wire logic         wb_ack_o,
  // controller pins
  input wire logic         transfer_enable_i,
  input wire logic         latch_i,
  input wire logic         bright_default_ctrl_i,
  input wire logic         blank_i,
  input wire logic         mode_i,
  input wire logic         scan_watch_input_i,
  input wire logic         thermal_guard_enable_i,
  input wire logic         over_temp_i,
  // outputs
  input wire logic [7:0]   cascade_data_out_o,
  input wire logic [15:0]  led_sink_outputs_o,
  input wire logic [4:0]   brightness_o,
  input wire logic         fault_oe_n_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_bright_force: assert property (!bright_default_ctrl_i [*6] |-> brightness_o == BC_DEFAULT)
    else $error("brightness not forced");
  a_shift_hold: assert property (transfer_enable_i [*8] |-> $stable(cascade_data_out_o))
    else $error("cascade moved while disabled");
  a_bright_hold: assert property (bright_default_ctrl_i && !latch_i [*8] |-> $stable(brightness_o))
    else $error("brightness latch not holding");
  a_blank_off: assert property (blank_i [*6] |-> led_sink_outputs_o == 16'h0000)
    else $error("outputs lit while blank");
  a_mode_eight: assert property (!mode_i [*6] |-> led_sink_outputs_o[15:8] == 8'h00)
    else $error("upper outputs lit in eight mode");
  a_therm_off: assert property (thermal_guard_enable_i && over_temp_i [*6] |-> led_sink_outputs_o == 0 && !fault_oe_n_o)
    else $error("thermal fault not forcing off");
  a_scan_clear: assert property ($changed(scan_watch_input_i) && !thermal_guard_enable_i |-> ##[1:6] fault_oe_n_o)
    else $error("fault not released after scan edge");
  a_fault_off: assert property (!fault_oe_n_o [*2] |-> led_sink_outputs_o == 16'h0000)
    else $error("outputs lit during fault");
  c_ack: cover property (wb_ack_o);
  c_lit: cover property (led_sink_outputs_o == 16'hffff);
  c_fault: cover property (!fault_oe_n_o);
endmodule
bind led_grayscale_pwm_driver led_pwm_chk chk (.*);

// ### led_pwm_pkg.sv
// led_pwm_pkg: constants, register map and carriers for the led gray-scale pwm driver
// assumes a single 250 MHz system clock; the display controller pins arrive asynchronously
package led_pwm_pkg;

  localparam int  NUM_OUT    = 16;
  localparam int  NUM_OUT8   = 8;
  localparam int  GS_W       = 8;
  localparam int  BC_W       = 5;
  localparam logic [BC_W-1:0] BC_DEFAULT = 5'h1f;
  localparam int  WD_W       = 24;

  // wishbone register offsets (byte addresses)
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_WDT    = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_MASK   = 4'hc;

  // control register fields
  localparam int  CTRL_WD_EN   = 0;
  localparam int  CTRL_WD_TIED = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [WD_W-1:0] WD_RESET = 24'h00ffff;

  // status and mask fields
  localparam int  ST_WDT   = 0;
  localparam int  ST_THERM = 1;
  localparam int  ST_LOAD  = 2;
  localparam int  ST_W     = 3;

  typedef struct packed {
    logic       enable_n;
    logic       select;
    logic       latch;
    logic       bright_default;
    logic       blank;
    logic       mode16;
    logic       scan;
    logic       thermal_en;
    logic       over_temp;
    logic [7:0] data;
  } ctl_pins_s;

  typedef enum logic [1:0] {
    PWM_BLANK = 2'b00,
    PWM_ARM   = 2'b01,
    PWM_RUN   = 2'b11
  } pwm_state_e;

endpackage

// ### test_led_grayscale_pwm_driver.sv
// test_led_grayscale_pwm_driver: scenario bench for the led driver
// assumes led_ctl_model drives the pins and led_pwm_chk is bound in
`timescale 1ns/100ps
module test_led_grayscale_pwm_driver;
  import led_pwm_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic        ack;
  logic        irq;
  logic        sclk;
  logic        gclk;
  ctl_pins_s   pins;
  logic [7:0]  casc;
  logic [15:0] led;
  logic [4:0]  bright;
  logic        fault_oe_n;
  int          bad_count = 0;
  int          check_count = 0;
  int          ticks = 0;
  always #2 clk = ~clk;
  led_ctl_model ctl (.clk_i(clk), .pins_o(pins), .shift_clock_o(sclk), .gray_clock_o(gclk));
  led_grayscale_pwm_driver DUT (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq),
    .shift_clock_i(sclk), .gray_count_clock_i(gclk), .transfer_enable_i(pins.enable_n),
    .register_select_i(pins.select), .latch_i(pins.latch), .bright_default_ctrl_i(pins.bright_default),
    .blank_i(pins.blank), .mode_i(pins.mode16), .scan_watch_input_i(pins.scan),
    .thermal_guard_enable_i(pins.thermal_en), .over_temp_i(pins.over_temp), .parallel_data_in_i(pins.data),
    .cascade_data_out_o(casc), .led_sink_outputs_o(led), .brightness_o(bright), .fault_o(),
    .fault_oe_n_o(fault_oe_n));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    ticks <= ticks + 1;
    if (ticks == 20000) begin
      bad_count++;
      wrap_up();
    end
  end
  // values are taken at the call, at a rising edge before any update lands
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    @(negedge clk);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
    @(posedge clk);
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
  endtask
  task automatic settle();
    repeat (8) @(posedge clk);
  endtask
  task automatic t_reset();
    check(bright, BC_DEFAULT);
    check(led, 32'h0);
    check(fault_oe_n, 32'h1);
    wb(1'b0, REG_WDT, 32'h0);
    check(rd, 32'h00ffff);
    wb(1'b1, 4'h1, 32'hff);
    wb(1'b0, 4'h1, 32'h0);
    check(rd, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_bright();
    ctl.shift_byte(8'h0a, 1'b1, 1'b0);
    ctl.pins_o.latch <= 1'b1;
    settle();
    check(bright, BC_DEFAULT);
    ctl.pins_o.bright_default <= 1'b1;
    settle();
    check(bright, 32'h0a);
    ctl.pins_o.latch <= 1'b0;
    ctl.shift_byte(8'h15, 1'b1, 1'b0);
    check(bright, 32'h0a);
    ctl.pins_o.latch <= 1'b1;
    settle();
    check(bright, 32'h15);
    ctl.shift_byte(8'h11, 1'b1, 1'b1);
    check(bright, 32'h15);
    ctl.pins_o.latch <= 1'b0;
    $display("brightness test done");
  endtask
  task automatic t_gray();
    for (int i = 0; i < 17; i++) ctl.shift_byte(8'h40 + 8'(i), 1'b0, 1'b0);
    check(casc, 32'h40);
    ctl.pins_o.mode16 <= 1'b0;
    for (int i = 0; i < 9; i++) ctl.shift_byte(8'h60 + 8'(i), 1'b0, 1'b0);
    check(casc, 32'h60);
    ctl.pins_o.mode16 <= 1'b1;
    for (int i = 0; i < 16; i++) ctl.shift_byte(8'h02, 1'b0, 1'b0);
    ctl.pins_o.latch <= 1'b1;
    settle();
    ctl.pins_o.latch <= 1'b0;
    wb(1'b0, REG_STATUS, 32'h0);
    check(rd, 32'h4);
    ctl.pins_o.blank <= 1'b0;
    settle();
    check(led, 32'h0);
    for (int k = 1; k < 4; k++) begin
      ctl.gray_pulse();
      check(led, k < 3 ? 32'hffff : 32'h0);
    end
    ctl.pins_o.blank <= 1'b1;
    ctl.pins_o.mode16 <= 1'b0;
    settle();
    ctl.pins_o.blank <= 1'b0;
    settle();
    ctl.gray_pulse();
    check(led, 32'h00ff);
    ctl.pins_o.blank <= 1'b1;
    settle();
    check(led, 32'h0);
    ctl.pins_o.mode16 <= 1'b1;
    ctl.pins_o.blank <= 1'b0;
    settle();
    ctl.gray_pulse();
    check(led, 32'hffff);
    $display("gray test done");
  endtask
  task automatic t_prot();
    wb(1'b1, REG_MASK, 32'h3);
    ctl.pins_o.thermal_en <= 1'b1;
    ctl.pins_o.over_temp <= 1'b1;
    settle();
    check({irq, fault_oe_n, led}, 32'h20000);
    ctl.pins_o.thermal_en <= 1'b0;
    settle();
    check({fault_oe_n, led}, 32'h10000);
    ctl.gray_pulse();
    check({fault_oe_n, led}, 32'h1ffff);
    wb(1'b1, REG_STATUS, 32'h7);
    wb(1'b0, REG_STATUS, 32'h0);
    check({irq, rd[30:0]}, 32'h0);
    wb(1'b1, REG_WDT, 32'h10);
    wb(1'b1, REG_CTRL, 32'h1);
    repeat (40) @(posedge clk);
    check({fault_oe_n, led}, 32'h0);
    ctl.pins_o.scan <= ~ctl.pins_o.scan;
    repeat (6) @(posedge clk);
    check({fault_oe_n, led}, 32'h10000);
    wb(1'b1, REG_CTRL, 32'h3);
    repeat (40) @(posedge clk);
    check({fault_oe_n, led}, 32'h10000);
    wb(1'b0, REG_STATUS, 32'h0);
    check({irq, rd[30:0]}, 32'h80000001);
    wb(1'b1, REG_MASK, 32'h0);
    check(irq, 32'h0);
    $display("protection test done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    settle();
    t_reset();
    t_bright();
    t_gray();
    t_prot();
    wrap_up();
  end
endmodule
